/* core/tuif_sync.sv */
/*
  Two flip-flop synchroniser for a bundle of pin levels.
  Assumes levels or strobes of several clocks.
*/
`timescale 1ns/1ns
`default_nettype none

module tuif_sync
#(
  parameter int W = 24
)
(
  input  wire logic         CLK,
  input  wire logic         RST_N,
  input  wire logic [W-1:0] D,
  output var  logic [W-1:0] Q
);

  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } tuif_sync_s;

  tuif_sync_s state_ff;
  tuif_sync_s nxt_state;

  always_comb
  begin
    nxt_state.meta = D;
    nxt_state.sync = state_ff.meta;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      state_ff <= '1;
    else
      state_ff <= nxt_state;
  end

  assign Q = state_ff.sync;

endmodule

`default_nettype wire

/* core/tuif_top.sv */
/*
  Formatter side of the link to up to four tape units, behind a register port.
  Assumes unit pins asynchronous to CLK and a master that never drives both strobes.
*/
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
`include "tuif_consts.svh"

// Rules of the tape unit link, for this block and for the unit
// R1: write status set low: unit drops to read mode within 20 us.
// R2: unit then stays in read mode until next motion command.
// R3: offline pulse reaches a rewinding, not-ready unit.
// R4: rewrite ramp level: unit ramps write current, cuts it after record.
// R5: density out low picks high density or PE, high low density or NRZI.
// R6: first threshold low gives high read threshold.
// R7: second threshold low gives extra-low read threshold.
// R8: falling amplifier shut-off starts early write/erase current turn-off.
// R9: amplifier shut-off also makes the unit emit the longitudinal check char.
// R10: write lines still through each strobe, one strobe per character.
// R11: odd write parity; line 0 msb for nine tracks, line 2 for seven.
// R12: write data line low for one, high for zero.
// R13: unit shows ready low only when loaded, not rewinding, online.
// R14: unit not ready about half a second after load point or rewind.
// R15: unit holds rewinding low for the whole rewind.
// R16: load point low only at reflector after load or rewind.
// R17: tape end level is noisy: filtered, never edge-trusted.
// R18: write protected low when no write ring fitted.
// R19: unit reports its type as static levels.
// R20: read character captured on rising trailing edge of read strobe.
// R21: read parity and data lines low for one; mapping as on write.
// R22: answers as formatter 1 when select low, formatter 0 when high.
// R23: two unit address levels decode to one of four units.
// R24: high/high unit 0, high/low 1, low/high 2, low/low 3.
// R25: one select line, gated by own address, picks the unit.
// R26: read strobe and status pass two flip-flops; edge found after.
module tuif_top
  import tuif_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [31:0] REG_RDATA,
  input  wire logic        READY_N,
  input  wire logic        UNIT_ONLINE_N,
  input  wire logic        UNIT_REWINDING_N,
  input  wire logic        WRITE_PROTECTED_N,
  input  wire logic        AT_LOAD_POINT_N,
  input  wire logic        TAPE_END_MARKER_N,
  input  wire logic        ENCODING_TYPE,
  input  wire logic        HEAD_STACK,
  input  wire logic        SPEED,
  input  wire logic        TRACK_COUNT,
  input  wire logic        DENSITY_INDICATOR,
  input  wire logic        READ_CHAR_STROBE_N,
  input  wire logic        READ_PARITY_BIT_N,
  input  wire logic [7:0]  READ_BIT_LINES_N,
  input  wire logic        FORMATTER_SELECT,
  input  wire logic        UNIT_SELECT_ADDR_A,
  input  wire logic        UNIT_SELECT_ADDR_B,
  output var  logic        FORWARD_MOTION_LEVEL_N,
  output var  logic        REVERSE_MOTION_LEVEL_N,
  output var  logic        WRITE_STATUS_SET_N,
  output var  logic        REWRITE_CURRENT_RAMP_N,
  output var  logic        DENSITY_CHOICE_OUT,
  output var  logic        HIGH_READ_THRESHOLD_N,
  output var  logic        EXTRA_LOW_READ_THRESHOLD_N,
  output var  logic        WRITE_AMP_SHUTOFF_N,
  output var  logic        REWIND_PULSE_N,
  output var  logic        GO_OFFLINE_PULSE_N,
  output var  logic        WRITE_CHAR_STROBE_N,
  output var  logic        WRITE_PARITY_BIT_N,
  output var  logic [7:0]  WRITE_BIT_LINES_N,
  output var  logic [3:0]  UNIT_SELECT_LINES_N
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // odd parity; seven-track uses bits 5:0
  function automatic logic odd_par(input logic [7:0] d, input logic seven);
    logic [7:0] m;
    m = seven ? {2'h0, d[5:0]} : d;
    return ~^m;
  endfunction

  // line i carries bit 7-i, so line 0 is the msb
  function automatic logic [7:0] to_lines(input logic [7:0] d);
    logic [7:0] r;
    for (int i = 0; i < 8; i++)
      r[i] = d[7-i];
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  tuif_pins_s  pins;
  logic [23:0] pins_raw;
  logic [23:0] pins_q;

  assign pins_raw = {READY_N, UNIT_ONLINE_N, UNIT_REWINDING_N, WRITE_PROTECTED_N,
                     AT_LOAD_POINT_N, TAPE_END_MARKER_N, ENCODING_TYPE, HEAD_STACK,
                     SPEED, TRACK_COUNT, DENSITY_INDICATOR, READ_CHAR_STROBE_N,
                     READ_PARITY_BIT_N, READ_BIT_LINES_N, FORMATTER_SELECT,
                     UNIT_SELECT_ADDR_A, UNIT_SELECT_ADDR_B};

  tuif_sync
  #(
    .W (24)
  )
  u_sync
  (
    .CLK   (CLK),
    .RST_N (RST_N),
    .D     (pins_raw),
    .Q     (pins_q)
  );

  assign pins = tuif_pins_s'(pins_q); // R26

  ////////////////////////////////////////////////////////////////////////////
  // state

  tuif_state_s state_ff;
  tuif_state_s nxt_state;

  logic        seven;
  logic        wr_hit;
  logic        rd_hit;
  logic        rds_rise;
  logic [7:0]  wr_char;
  logic [7:0]  rd_char;
  logic        match;
  logic [1:0]  unit_idx;
  logic [31:0] status_word;

  always_comb
  begin
    nxt_state   = state_ff;
    seven       = ~pins.track_count;
    wr_hit      = 1'b0;
    rd_hit      = 1'b0;
    rds_rise    = 1'b0;
    wr_char     = 8'h00;
    rd_char     = 8'h00;
    match       = 1'b0;
    unit_idx    = 2'h0;
    status_word = 32'h0000_0000;

    // synchronised unit levels
    status_word[10:0] = {pins.ready_n, pins.unit_online_n, pins.unit_rewinding_n,
                         pins.write_protected_n, pins.at_load_point_n,
                         pins.tape_end_marker_n, pins.encoding_type, pins.head_stack,
                         pins.speed, pins.track_count, pins.density_indicator};
    status_word[`TUIF_ST_END_FLT]  = state_ff.end_flt;
    status_word[`TUIF_ST_WR_BUSY]  = (state_ff.wr_st != TUIF_WR_IDLE);
    status_word[`TUIF_ST_CMD_BUSY] = (state_ff.cmd_cnt != 16'h0000);
    status_word[`TUIF_ST_WR_DROP]  = state_ff.wr_drop;
    status_word[`TUIF_ST_SELECTED] = ~&state_ff.sel_n;

    //////////////////////////////////////////////////////////////////////////
    // register port: read data only in the cycle after the read strobe

    nxt_state.rdata = 32'h0000_0000;
    if (REG_RD)
    begin
      if (REG_ADDR == `TUIF_OFS_CTRL)
        nxt_state.rdata = {23'h0, state_ff.ctrl};
      else if (REG_ADDR == `TUIF_OFS_RDATA)
      begin
        rd_hit                             = 1'b1;
        nxt_state.rdata[7:0]               = state_ff.rd_data;
        nxt_state.rdata[`TUIF_RD_PAR]      = state_ff.rd_par;
        nxt_state.rdata[`TUIF_RD_PERR]     = state_ff.rd_perr;
        nxt_state.rdata[`TUIF_RD_VALID]    = state_ff.rd_valid;
        nxt_state.rdata[`TUIF_RD_OVR]      = state_ff.rd_ovr;
      end
      else if (REG_ADDR == `TUIF_OFS_STATUS)
        nxt_state.rdata = status_word;
    end

    if (REG_WR)
    begin
      if (REG_ADDR == `TUIF_OFS_CTRL)
        nxt_state.ctrl = REG_WDATA[`TUIF_CTRL_W-1:0];
      else if (REG_ADDR == `TUIF_OFS_CMD)
      begin
        // no ready gating: offline must reach a rewinding unit
        if (state_ff.cmd_cnt == 16'h0000 && REG_WDATA[1:0] != 2'h0) // R3
        begin
          nxt_state.cmd_pulse = REG_WDATA[1:0];
          nxt_state.cmd_cnt   = 16'(`TUIF_CMD_PULSE_CYC);
        end
      end
      else if (REG_ADDR == `TUIF_OFS_WDATA)
        wr_hit = 1'b1;
      else if (REG_ADDR == `TUIF_OFS_STATUS)
      begin
        if (REG_WDATA[`TUIF_ST_WR_DROP])
          nxt_state.wr_drop = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // command pulses, fixed width

    if (state_ff.cmd_cnt != 16'h0000)
    begin
      nxt_state.cmd_cnt = state_ff.cmd_cnt - 16'h0001;
      if (state_ff.cmd_cnt == 16'h0001)
        nxt_state.cmd_pulse = 2'h0;
    end

    //////////////////////////////////////////////////////////////////////////
    // write character sequencer: lines settle, strobe low, lines held

    if (state_ff.wr_cnt != 16'h0000)
      nxt_state.wr_cnt = state_ff.wr_cnt - 16'h0001;

    case (state_ff.wr_st)
      TUIF_WR_IDLE:
      begin
        if (wr_hit)
        begin
          wr_char              = seven ? {2'h0, REG_WDATA[5:0]} : REG_WDATA[7:0];
          nxt_state.wr_lines_n = ~to_lines(wr_char);          // R11 R12
          nxt_state.wr_par_n   = ~odd_par(wr_char, seven);    // R11 R12
          nxt_state.wr_cnt     = 16'(`TUIF_WR_SETUP_CYC - 1);
          nxt_state.wr_st      = TUIF_WR_SETUP;
        end
      end
      TUIF_WR_SETUP:
      begin
        if (state_ff.wr_cnt == 16'h0000)
        begin
          nxt_state.wr_strobe_n = 1'b0;                       // R10
          nxt_state.wr_cnt      = 16'(`TUIF_WR_PULSE_CYC - 1);
          nxt_state.wr_st       = TUIF_WR_PULSE;
        end
      end
      TUIF_WR_PULSE:
      begin
        if (state_ff.wr_cnt == 16'h0000)
        begin
          nxt_state.wr_strobe_n = 1'b1;                       // R10
          nxt_state.wr_cnt      = 16'(`TUIF_WR_HOLD_CYC - 1);
          nxt_state.wr_st       = TUIF_WR_HOLD;
        end
      end
      TUIF_WR_HOLD:
      begin
        // lines held so the unit latches a still char
        if (state_ff.wr_cnt == 16'h0000)
          nxt_state.wr_st = TUIF_WR_IDLE;                     // R10
      end
      default:
      begin
        nxt_state.wr_st       = TUIF_WR_IDLE;
        nxt_state.wr_strobe_n = 1'b1;
      end
    endcase

    // a character offered while busy is dropped and flagged
    if (wr_hit && state_ff.wr_st != TUIF_WR_IDLE)
      nxt_state.wr_drop = 1'b1;

    //////////////////////////////////////////////////////////////////////////
    // tape end filter: believe only a steady level

    if (pins.tape_end_marker_n == ~state_ff.end_flt)
      nxt_state.end_cnt = 16'h0000;
    else if (state_ff.end_cnt == 16'(`TUIF_END_FILT_CYC - 1))
    begin
      nxt_state.end_flt = ~pins.tape_end_marker_n;            // R17
      nxt_state.end_cnt = 16'h0000;
    end
    else
      nxt_state.end_cnt = state_ff.end_cnt + 16'h0001;        // R17

    //////////////////////////////////////////////////////////////////////////
    // read characters: hold lines while strobe low, commit on its rise

    nxt_state.rds_prev = pins.read_char_strobe_n;
    rds_rise           = pins.read_char_strobe_n & ~state_ff.rds_prev;  // R20 R26
    if (!pins.read_char_strobe_n)
      nxt_state.rd_hold_n = {pins.read_parity_bit_n, pins.read_bit_lines_n};

    // reading clears valid and overrun; a new character in the same cycle wins
    if (rd_hit)
    begin
      nxt_state.rd_valid = 1'b0;
      nxt_state.rd_ovr   = 1'b0;
    end
    if (rds_rise)
    begin
      rd_char = to_lines(~state_ff.rd_hold_n[7:0]);           // R21
      if (seven)
        rd_char[7:6] = 2'h0;                                  // R21
      nxt_state.rd_data  = rd_char;
      nxt_state.rd_par   = ~state_ff.rd_hold_n[8];            // R21
      nxt_state.rd_perr  = (~state_ff.rd_hold_n[8]) != odd_par(rd_char, seven);
      nxt_state.rd_valid = 1'b1;                              // R20
      if (state_ff.rd_valid && !rd_hit)
        nxt_state.rd_ovr = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // unit select: address held still by the controller

    match    = pins.formatter_select ^ state_ff.ctrl[`TUIF_CTRL_OWN_ADDR]; // R22
    unit_idx = {~pins.unit_select_addr_a, ~pins.unit_select_addr_b};      // R23 R24
    if (match)
      nxt_state.sel_n = ~(4'h1 << unit_idx);                  // R25
    else
      nxt_state.sel_n = 4'hf;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_ff             <= '0;
      state_ff.ctrl        <= `TUIF_CTRL_RESET;
      state_ff.wr_st       <= TUIF_WR_IDLE;
      state_ff.wr_lines_n  <= 8'hff;
      state_ff.wr_par_n    <= 1'b1;
      state_ff.wr_strobe_n <= 1'b1;
      state_ff.rds_prev    <= 1'b1;
      state_ff.rd_hold_n   <= 9'h1ff;
      state_ff.sel_n       <= 4'hf;
    end
    else
      state_ff <= nxt_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign REG_RDATA                  = state_ff.rdata;
  assign FORWARD_MOTION_LEVEL_N     = ~state_ff.ctrl[`TUIF_CTRL_FWD];
  assign REVERSE_MOTION_LEVEL_N     = ~state_ff.ctrl[`TUIF_CTRL_REV];
  assign WRITE_STATUS_SET_N         = ~state_ff.ctrl[`TUIF_CTRL_WSS];
  assign REWRITE_CURRENT_RAMP_N     = ~state_ff.ctrl[`TUIF_CTRL_RAMP];
  assign DENSITY_CHOICE_OUT         = state_ff.ctrl[`TUIF_CTRL_DENS_LOW];   // R5
  assign HIGH_READ_THRESHOLD_N      = ~state_ff.ctrl[`TUIF_CTRL_THR_HIGH];
  assign EXTRA_LOW_READ_THRESHOLD_N = ~state_ff.ctrl[`TUIF_CTRL_THR_XLOW];
  assign WRITE_AMP_SHUTOFF_N        = ~state_ff.ctrl[`TUIF_CTRL_AMP_OFF];
  assign REWIND_PULSE_N             = ~state_ff.cmd_pulse[`TUIF_CMD_REWIND];
  assign GO_OFFLINE_PULSE_N         = ~state_ff.cmd_pulse[`TUIF_CMD_OFFLINE]; // R3
  assign WRITE_CHAR_STROBE_N        = state_ff.wr_strobe_n;
  assign WRITE_PARITY_BIT_N         = state_ff.wr_par_n;
  assign WRITE_BIT_LINES_N          = state_ff.wr_lines_n;
  assign UNIT_SELECT_LINES_N        = state_ff.sel_n;

endmodule

`default_nettype wire

/* dv/tb.sv */
/*
  Bench of the tape unit interface with a tape unit model.
  Assumes the checker binds itself.
*/
`timescale 1ns/1ns
`default_nettype none

module tb;
  logic        CLK, RST_N, REG_WR, REG_RD;
  logic [7:0]  REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA;
  logic [10:0] st;
  wire logic   READY_N, UNIT_ONLINE_N, UNIT_REWINDING_N, WRITE_PROTECTED_N, AT_LOAD_POINT_N;
  wire logic   TAPE_END_MARKER_N, ENCODING_TYPE, HEAD_STACK, SPEED, TRACK_COUNT, DENSITY_INDICATOR;
  logic        READ_CHAR_STROBE_N, READ_PARITY_BIT_N, FORMATTER_SELECT, UNIT_SELECT_ADDR_A, UNIT_SELECT_ADDR_B;
  logic [7:0]  READ_BIT_LINES_N, WRITE_BIT_LINES_N, rnd, l;
  logic        FORWARD_MOTION_LEVEL_N, REVERSE_MOTION_LEVEL_N, WRITE_STATUS_SET_N, REWRITE_CURRENT_RAMP_N;
  logic        DENSITY_CHOICE_OUT, HIGH_READ_THRESHOLD_N, EXTRA_LOW_READ_THRESHOLD_N, WRITE_AMP_SHUTOFF_N;
  logic        REWIND_PULSE_N, GO_OFFLINE_PULSE_N, WRITE_CHAR_STROBE_N, WRITE_PARITY_BIT_N, rd_p = 1'b0;
  logic [3:0]  UNIT_SELECT_LINES_N, sel_e;
  logic [63:0] exp_q[$];
  logic [8:0]  wexp_q[$], c;
  int          miscompares, total_checks;

  assign {READY_N, UNIT_ONLINE_N, UNIT_REWINDING_N, WRITE_PROTECTED_N, AT_LOAD_POINT_N, TAPE_END_MARKER_N,
          ENCODING_TYPE, HEAD_STACK, SPEED, TRACK_COUNT, DENSITY_INDICATOR} = st;

  tuif_top        tuif_top_i (.*);
  tuif_unit_model tuif_unit_model_i (.*);

  ////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function automatic logic [7:0] rev8(input logic [7:0] x);
    for (int k = 0; k < 8; k++)
      rev8[k] = x[7 - k];
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (miscompares == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one idle edge after each access
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    exp_q.push_back({m, v});
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    @(posedge CLK);
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end

  always @(negedge CLK)
  begin
    if (rd_p)
    begin
      check(REG_RDATA & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    rd_p = REG_RD;
  end

  initial
  begin
    @(posedge RST_N);
    forever
    begin
      @(posedge WRITE_CHAR_STROBE_N);
      #1;
      check(tuif_unit_model_i.last_ch, wexp_q.pop_front());
    end
  end

  initial
  begin
    #200000;
    miscompares++;
    stop_test();
  end

  initial
  begin
    {RST_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    {FORMATTER_SELECT, UNIT_SELECT_ADDR_A, UNIT_SELECT_ADDR_B} = 3'h7;
    st = 11'h7ff;
    rnd = 8'h5c;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    @(posedge CLK);
    rd(8'h00, 32'h1ff, 32'h010);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'hffffffff, 32'h0);
    rd(8'h00, 32'h1ff, 32'h010);
    check(DENSITY_CHOICE_OUT, 1'b1);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      wr(8'h00, {23'h0, rnd[1], rnd});
      rd(8'h00, 32'h1ff, {23'h0, rnd[1], rnd});
    end
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h00, {23'h0, i[3], 8'h00});
      {FORMATTER_SELECT, UNIT_SELECT_ADDR_A, UNIT_SELECT_ADDR_B} <= i[2:0];
      sel_e = (i[2] != i[3]) ? ~(4'h1 << {~i[1], ~i[0]}) : 4'hf;
      repeat (5) @(posedge CLK);
      @(negedge CLK);
      check(UNIT_SELECT_LINES_N, sel_e);
      @(posedge CLK);
    end
    check(DENSITY_CHOICE_OUT, 1'b0);
    // unit not ready and rewinding, offline must still go out
    st[8] <= 1'b0;
    wr(8'h04, 32'h1);
    repeat (60) @(posedge CLK);
    wr(8'h04, 32'h2);
    wr(8'h04, 32'h1);
    @(negedge CLK);
    check({GO_OFFLINE_PULSE_N, REWIND_PULSE_N}, 2'b01);
    repeat (60) @(posedge CLK);
    rnd = lfsr(rnd);
    st <= {rnd[2:0], rnd};
    repeat (4) @(posedge CLK);
    rd(8'h10, 32'h7ff, {21'h0, rnd[2:0], rnd});
    repeat (20)
    begin
      st[5] <= ~st[5];
      repeat (7) @(posedge CLK);
    end
    rd(8'h10, 32'h800, 32'h0);
    st[5] <= 1'b0;
    repeat (520) @(posedge CLK);
    rd(8'h10, 32'h800, 32'h800);
    for (int t = 1; t >= 0; t--)
    begin
      st[1] <= t[0];
      rnd = lfsr(rnd);
      l = rev8(t[0] ? rnd : rnd & 8'h3f);
      wexp_q.push_back({~^l, l});
      repeat (4) @(posedge CLK);
      wr(8'h08, {24'h0, rnd});
      wr(8'h08, 32'h0);
      rd(8'h10, 32'h4000, 32'h4000);
      wr(8'h10, 32'h4000);
      repeat (100) @(posedge CLK);
      rd(8'h10, 32'h5000, 32'h0);
    end
    st[1] <= 1'b1;
    repeat (4) @(posedge CLK);
    for (int j = 0; j < 3; j++)
    begin
      rnd = lfsr(rnd);
      c = {(~^rnd) ^ (j == 1), rnd};
      tuif_unit_model_i.send(c);
      if (j == 2)
        tuif_unit_model_i.send(c);
      repeat (4) @(posedge CLK);
      rd(8'h0c, 32'hfff, {20'h0, j == 2, 1'b1, j == 1, c[8], rev8(c[7:0])});
    end
    rd(8'h0c, 32'hc00, 32'h0);
    stop_test();
  end
endmodule

`default_nettype wire

/* dv/tuif_assertions.sv */
/*
  Port checker of the tape unit interface top.
  Assumes bind onto tuif_top and a single CLK domain.
*/
`timescale 1ns/1ns
`default_nettype none

module tuif_assertions
(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [7:0]  REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        FORMATTER_SELECT,
  input wire logic        UNIT_SELECT_ADDR_A,
  input wire logic        UNIT_SELECT_ADDR_B,
  input wire logic        FORWARD_MOTION_LEVEL_N,
  input wire logic        REVERSE_MOTION_LEVEL_N,
  input wire logic        WRITE_STATUS_SET_N,
  input wire logic        REWRITE_CURRENT_RAMP_N,
  input wire logic        DENSITY_CHOICE_OUT,
  input wire logic        HIGH_READ_THRESHOLD_N,
  input wire logic        EXTRA_LOW_READ_THRESHOLD_N,
  input wire logic        WRITE_AMP_SHUTOFF_N,
  input wire logic        REWIND_PULSE_N,
  input wire logic        GO_OFFLINE_PULSE_N,
  input wire logic        WRITE_CHAR_STROBE_N,
  input wire logic        WRITE_PARITY_BIT_N,
  input wire logic [7:0]  WRITE_BIT_LINES_N,
  input wire logic [3:0]  UNIT_SELECT_LINES_N
);
  logic [6:0] rew_ff, off_ff, stb_ff;
  logic [2:0] up_ff;
  logic       own_ff;
  logic [3:0] sel_exp;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  assign sel_exp = (FORMATTER_SELECT != own_ff) ? ~(4'h1 << {~UNIT_SELECT_ADDR_A, ~UNIT_SELECT_ADDR_B}) : 4'hf;

  // low-time counters, read at the rising edge of each pulse
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      rew_ff <= 7'h0;
      off_ff <= 7'h0;
      stb_ff <= 7'h0;
      up_ff  <= 3'h0;
      own_ff <= 1'b0;
    end
    else
    begin
      rew_ff <= REWIND_PULSE_N ? 7'h0 : rew_ff + 7'h1;
      off_ff <= GO_OFFLINE_PULSE_N ? 7'h0 : off_ff + 7'h1;
      stb_ff <= WRITE_CHAR_STROBE_N ? 7'h0 : stb_ff + 7'h1;
      up_ff  <= (up_ff == 3'h7) ? up_ff : up_ff + 3'h1;
      own_ff <= (REG_WR && REG_ADDR == 8'h00) ? REG_WDATA[8] : own_ff;
    end

  ////////////////////////////////////////////////////////////
  sequence s_addr_still;
    (up_ff == 3'h7 && $stable({FORMATTER_SELECT, UNIT_SELECT_ADDR_A, UNIT_SELECT_ADDR_B, own_ff}))[*5];
  endsequence

  sequence s_off_cmd;
    REG_WR && REG_ADDR == 8'h04 && REG_WDATA[1] && REWIND_PULSE_N && GO_OFFLINE_PULSE_N
      && !$past(REG_WR && REG_ADDR == 8'h04);
  endsequence

  property p_ctrl;
    logic [7:0] d;
    (REG_WR && REG_ADDR == 8'h00, d = REG_WDATA[7:0]) |-> ##2
      {WRITE_AMP_SHUTOFF_N, EXTRA_LOW_READ_THRESHOLD_N, HIGH_READ_THRESHOLD_N, ~DENSITY_CHOICE_OUT,
       REWRITE_CURRENT_RAMP_N, WRITE_STATUS_SET_N, REVERSE_MOTION_LEVEL_N, FORWARD_MOTION_LEVEL_N} == ~d;
  endproperty

  a_ctrl_levels: assert property (p_ctrl)
    else $error("control levels differ from control write");
  a_rd_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
    else $error("read data not zero outside read cycle");
  a_off_start: assert property (s_off_cmd |-> ##[1:2] !GO_OFFLINE_PULSE_N)
    else $error("offline pulse did not start");
  a_off_width: assert property ($rose(GO_OFFLINE_PULSE_N) |-> off_ff == 7'd50)
    else $error("offline pulse width wrong");
  a_rew_width: assert property ($rose(REWIND_PULSE_N) |-> rew_ff == 7'd50)
    else $error("rewind pulse width wrong");
  a_wr_width: assert property ($rose(WRITE_CHAR_STROBE_N) |-> stb_ff == 7'd50)
    else $error("write strobe width wrong");
  a_wr_still: assert property (!WRITE_CHAR_STROBE_N |-> $stable({WRITE_BIT_LINES_N, WRITE_PARITY_BIT_N}))
    else $error("write lines moved under strobe");
  a_wr_parity: assert property ($fell(WRITE_CHAR_STROBE_N) |-> !(^{WRITE_BIT_LINES_N, WRITE_PARITY_BIT_N}))
    else $error("write parity not odd");
  a_sel_decode: assert property (s_addr_still |-> UNIT_SELECT_LINES_N == sel_exp)
    else $error("unit select decode wrong");
endmodule

bind tuif_top tuif_assertions tuif_assertions_i (.*);

`default_nettype wire

/* dv/tuif_unit_model.sv */
/*
  Tape unit model: latches written and sends read characters.
  Assumes the bench calls send.
*/
`timescale 1ns/1ns
`default_nettype none

module tuif_unit_model
(
  input  wire logic       WRITE_CHAR_STROBE_N,
  input  wire logic       WRITE_PARITY_BIT_N,
  input  wire logic [7:0] WRITE_BIT_LINES_N,
  output var  logic       READ_CHAR_STROBE_N,
  output var  logic       READ_PARITY_BIT_N,
  output var  logic [7:0] READ_BIT_LINES_N
);
  logic [8:0] last_ch;

  initial
  begin
    READ_CHAR_STROBE_N = 1'b1;
    {READ_PARITY_BIT_N, READ_BIT_LINES_N} = 9'h0a5;
  end

  // latched on the trailing edge only, lines low for one
  always @(posedge WRITE_CHAR_STROBE_N)
    last_ch <= ~{WRITE_PARITY_BIT_N, WRITE_BIT_LINES_N};

  ////////////////////////////////////////////////////////////
  // odd start keeps edges off CLK edges
  task automatic send(input logic [8:0] c);
    #7 {READ_PARITY_BIT_N, READ_BIT_LINES_N} = ~c;
    #40 READ_CHAR_STROBE_N = 1'b0;
    #80 READ_CHAR_STROBE_N = 1'b1;
    // released lines show the inverse
    #40 {READ_PARITY_BIT_N, READ_BIT_LINES_N} = c;
  endtask
endmodule

`default_nettype wire

/* inc/tuif_consts.svh */
/*
  Offsets, fields, reset values and timing counts of the tape unit block.
  Assumes a 50 MHz clock and byte addresses.
*/
`ifndef TUIF_CONSTS_SVH
`define TUIF_CONSTS_SVH

`define TUIF_CLK_MHZ          50

// register byte offsets
`define TUIF_OFS_CTRL         8'h00
`define TUIF_OFS_CMD          8'h04
`define TUIF_OFS_WDATA        8'h08
`define TUIF_OFS_RDATA        8'h0c
`define TUIF_OFS_STATUS       8'h10

// control register fields
`define TUIF_CTRL_FWD         0
`define TUIF_CTRL_REV         1
`define TUIF_CTRL_WSS         2
`define TUIF_CTRL_RAMP        3
`define TUIF_CTRL_DENS_LOW    4
`define TUIF_CTRL_THR_HIGH    5
`define TUIF_CTRL_THR_XLOW    6
`define TUIF_CTRL_AMP_OFF     7
`define TUIF_CTRL_OWN_ADDR    8
`define TUIF_CTRL_W           9
`define TUIF_CTRL_RESET       9'h010

// command register fields
`define TUIF_CMD_REWIND       0
`define TUIF_CMD_OFFLINE      1

// read data register fields
`define TUIF_RD_PAR           8
`define TUIF_RD_PERR          9
`define TUIF_RD_VALID         10
`define TUIF_RD_OVR           11

// status fields
`define TUIF_ST_END_FLT       11
`define TUIF_ST_WR_BUSY       12
`define TUIF_ST_CMD_BUSY      13
`define TUIF_ST_WR_DROP       14
`define TUIF_ST_SELECTED      15

// times in ns and their cycle counts
`define TUIF_WR_SETUP_NS      500
`define TUIF_WR_PULSE_NS      1000
`define TUIF_WR_HOLD_NS       500
`define TUIF_CMD_PULSE_NS     1000
`define TUIF_END_FILT_NS      10000
`define TUIF_WR_SETUP_CYC     ((`TUIF_WR_SETUP_NS * `TUIF_CLK_MHZ + 999) / 1000)
`define TUIF_WR_PULSE_CYC     ((`TUIF_WR_PULSE_NS * `TUIF_CLK_MHZ + 999) / 1000)
`define TUIF_WR_HOLD_CYC      ((`TUIF_WR_HOLD_NS * `TUIF_CLK_MHZ + 999) / 1000)
`define TUIF_CMD_PULSE_CYC    ((`TUIF_CMD_PULSE_NS * `TUIF_CLK_MHZ + 999) / 1000)
`define TUIF_END_FILT_CYC     ((`TUIF_END_FILT_NS * `TUIF_CLK_MHZ + 999) / 1000)

`endif

/* inc/tuif_pkg.sv */
/*
  Types of the tape unit interface block.
  Assumes tuif_consts.svh.
*/
`include "tuif_consts.svh"

package tuif_pkg;

  typedef enum logic [1:0]
  {
    TUIF_WR_IDLE  = 2'h0,
    TUIF_WR_SETUP = 2'h1,
    TUIF_WR_PULSE = 2'h3,
    TUIF_WR_HOLD  = 2'h2
  } tuif_wr_e;

  typedef struct packed
  {
    logic       ready_n;
    logic       unit_online_n;
    logic       unit_rewinding_n;
    logic       write_protected_n;
    logic       at_load_point_n;
    logic       tape_end_marker_n;
    logic       encoding_type;
    logic       head_stack;
    logic       speed;
    logic       track_count;
    logic       density_indicator;
    logic       read_char_strobe_n;
    logic       read_parity_bit_n;
    logic [7:0] read_bit_lines_n;
    logic       formatter_select;
    logic       unit_select_addr_a;
    logic       unit_select_addr_b;
  } tuif_pins_s;

  typedef struct packed
  {
    logic [`TUIF_CTRL_W-1:0] ctrl;
    tuif_wr_e                wr_st;
    logic [15:0]             wr_cnt;
    logic [7:0]              wr_lines_n;
    logic                    wr_par_n;
    logic                    wr_strobe_n;
    logic                    wr_drop;
    logic [15:0]             cmd_cnt;
    logic [1:0]              cmd_pulse;
    logic [15:0]             end_cnt;
    logic                    end_flt;
    logic                    rds_prev;
    logic [8:0]              rd_hold_n;
    logic [7:0]              rd_data;
    logic                    rd_par;
    logic                    rd_perr;
    logic                    rd_valid;
    logic                    rd_ovr;
    logic [3:0]              sel_n;
    logic [31:0]             rdata;
  } tuif_state_s;

endpackage
